//--- src/wpts_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE_01) Sync pulses once at the start of every outer pass.
// (RULE_02) Inner loop returns never produce a sync pulse.
// (RULE_03) Free run starts on computation done, runs n passes, restarts via run toggle.
// (RULE_04) After the last pass the output holds the last sample.
// (RULE_05) Edge start begins on the next active edge and runs all passes.
// (RULE_06) Edge start ignores edges during playback.
// (RULE_07) After an equation ends, edges are refused for at least 0.5 us.
// (RULE_08) Edge start restarts the whole sequence on the next accepted edge.
// (RULE_09) Edge stop starts on computation done, halts after n passes or an edge.
// (RULE_10) After edge stop, edges do nothing until run is toggled.
// (RULE_11) Start-to-stop starts on an edge, stops on n passes or edge.
// (RULE_12) Gated output runs only while gate active and not complete.
// (RULE_13) Gate inactive stops output; gate active again restarts it.
// (RULE_14) Unselected trigger mode behaves as free run.
// (RULE_15) Triggers support both polarities, positive by default.
// (RULE_16) Marker rises a programmed delay after sync leading edge.
// (RULE_17) Noise band accepts only 2 MHz, 200 kHz or 20 kHz.
// (RULE_18) Low-pass select accepts exactly one of ten cutoffs.
// (RULE_19) Offset adds to samples; result held within full scale.
// (RULE_20) Modifier and clock settings change at run time, memory untouched.
// (RULE_21) Pass and inner repeat counts range 1 to 65535.
// (RULE_22) High speed mode pads each repeated sequence to 16 samples.
// (RULE_23) Trigger is synchronised and edge detected before use.
module wpts_seq #(
  parameter int                          AW     = wpts_pkg::AW,
  parameter int                          SW     = wpts_pkg::SAMPLE_W,
  parameter int                          DEPTH  = wpts_pkg::FIFO_DEPTH,
  parameter logic signed [SW-1:0]        FS_POS = wpts_pkg::FS_POS,
  parameter logic signed [SW-1:0]        FS_NEG = wpts_pkg::FS_NEG
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // Trigger pin and scheme
  input  wire logic                      i_trig_pin,
  input  wire logic [2:0]                i_trig_mode,
  input  wire logic                      i_trig_neg,
  // Run control
  input  wire logic                      i_run,
  input  wire logic                      i_compute_done,
  input  wire logic                      i_hs_mode,
  // Equation layout
  input  wire logic [AW-1:0]             i_seq_len,
  input  wire logic [wpts_pkg::LOOP_W-1:0] i_loop_directive,
  input  wire logic [AW-1:0]             i_inner_start,
  input  wire logic [AW-1:0]             i_inner_len,
  input  wire logic [wpts_pkg::LOOP_W-1:0] i_inner_count,
  // Modifiers
  input  wire logic                      i_mod_wr,
  input  wire logic [SW-1:0]             i_dc_shift,
  input  wire logic [SW-1:0]             i_noise_level,
  input  wire logic [1:0]                i_noise_band,
  input  wire logic [3:0]                i_lowpass_select,
  input  wire logic [wpts_pkg::MARK_W-1:0] i_marker_delay,
  input  wire logic [wpts_pkg::DIV_W-1:0]  i_rate_div,
  // Output memory
  output logic                           o_mem_rd,
  output logic [AW-1:0]                  o_mem_addr,
  input  wire logic [SW-1:0]             i_mem_data,
  // DAC path
  output logic                           o_sample_vld,
  output logic [SW-1:0]                  o_sample,
  output logic                           o_sync,
  output logic                           o_marker,
  output logic [SW-1:0]                  o_noise_level,
  output logic [1:0]                     o_noise_band,
  output logic [3:0]                     o_lowpass_select,
  output logic                           o_playing
);
  localparam int CW = $clog2(DEPTH + 1);

  wpts_pkg::wpts_state_t st_r;
  logic [2:0]                   mode_r;
  logic                         trig_lvl;
  logic                         trig_edge;
  logic [AW-1:0]                addr_r;
  logic [wpts_pkg::LOOP_W-1:0]  pass_r;
  logic [wpts_pkg::LOOP_W-1:0]  rep_r;
  logic [wpts_pkg::PAD_W-1:0]   ocnt_r;
  logic [wpts_pkg::PAD_W-1:0]   icnt_r;
  logic                         first_r;
  logic [wpts_pkg::DEAD_W-1:0]  dead_r;
  logic                         abort_r;
  logic [SW-1:0]                shift_r;
  logic [wpts_pkg::DIV_W-1:0]   div_r;
  logic [wpts_pkg::DIV_W-1:0]   rate_r;
  logic [wpts_pkg::MARK_W-1:0]  mark_cnt_r;
  logic                         mark_pend_r;
  logic [wpts_pkg::MARK_W-1:0]  mark_dly_r;
  logic                         fifo_rdy;
  logic                         fifo_vld;
  logic [SW:0]                  fifo_dat;
  logic [CW-1:0]                fifo_cnt;
  logic                         tick;
  logic                         drain;
  logic                         room;
  logic                         issue;
  logic                         stop_now;
  logic                         eq_end;
  logic                         inner_on;
  logic                         at_inner;
  logic                         at_outer;
  logic                         pad_in;
  logic                         pad_out;
  logic [wpts_pkg::LOOP_W-1:0]  passes;
  logic [AW-1:0]                inner_end;
  logic signed [SW:0]           sum;

  wpts_trig_cond u_trig (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_pin     (i_trig_pin),
    .i_neg     (i_trig_neg),
    .o_level_r (trig_lvl),
    .o_edge_r  (trig_edge)
  );

  // A slot is kept for the read in flight so memory data is never dropped by a full buffer
  assign room  = ({1'b0, fifo_cnt} + {{CW{1'b0}}, o_mem_rd}) < (CW + 1)'(DEPTH);
  assign tick  = (rate_r == '0);
  assign drain = tick & fifo_vld;

  // Zero counts run one pass
  assign passes    = (i_loop_directive == '0) ? 16'h0001 : i_loop_directive; // RULE_21
  assign inner_on  = (i_inner_count > 16'h0001) && (i_inner_len != '0);   // RULE_21
  assign inner_end = AW'(i_inner_start + i_inner_len - 1'b1);
  assign pad_in    = i_hs_mode && (icnt_r != wpts_pkg::PAD_LAST);          // RULE_22
  assign pad_out   = i_hs_mode && (ocnt_r != wpts_pkg::PAD_LAST);          // RULE_22
  assign at_inner  = inner_on && (addr_r == inner_end) && (rep_r != i_inner_count - 1'b1);
  assign at_outer  = (addr_r == AW'(i_seq_len - 1'b1));
  assign eq_end    = issue && at_outer && !pad_out && !at_inner && (pass_r == passes - 1'b1);

  always_comb begin
    stop_now = 1'b0;
    if (st_r == wpts_pkg::S_RUN) begin
      unique case (mode_r)
        wpts_pkg::MODE_STOP,
        wpts_pkg::MODE_SS:    stop_now = trig_edge;  // RULE_09 RULE_11
        wpts_pkg::MODE_GATED: stop_now = !trig_lvl;  // RULE_12 RULE_13
        default:              stop_now = 1'b0;       // RULE_06
      endcase
    end
  end

  assign issue = (st_r == wpts_pkg::S_RUN) && room && fifo_rdy && !stop_now;

  // Scheme latched at start so a change mid pass cannot confuse the sequencer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_r <= wpts_pkg::MODE_FREE;
    end else if (st_r == wpts_pkg::S_IDLE) begin
      mode_r <= wpts_pkg::wpts_mode_f(i_trig_mode); // RULE_14
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      st_r <= wpts_pkg::S_IDLE; // RULE_03 RULE_10
    end else begin
      unique case (st_r)
        wpts_pkg::S_IDLE: begin
          if (i_compute_done) begin
            if (mode_r == wpts_pkg::MODE_FREE || mode_r == wpts_pkg::MODE_STOP) begin
              st_r <= wpts_pkg::S_RUN; // RULE_03 RULE_09
            end else begin
              st_r <= wpts_pkg::S_ARMED;
            end
          end
        end
        wpts_pkg::S_ARMED: begin
          if (trig_edge) begin
            st_r <= wpts_pkg::S_RUN; // RULE_05 RULE_08 RULE_11 RULE_13
          end
        end
        wpts_pkg::S_RUN: begin
          if (stop_now) begin
            if (mode_r == wpts_pkg::MODE_STOP) begin
              st_r <= wpts_pkg::S_HALT; // RULE_09
            end else if (mode_r == wpts_pkg::MODE_GATED) begin
              st_r <= wpts_pkg::S_ARMED; // RULE_13
            end else begin
              st_r <= wpts_pkg::S_DEAD; // RULE_11
            end
          end else if (eq_end) begin
            if (mode_r == wpts_pkg::MODE_FREE || mode_r == wpts_pkg::MODE_STOP) begin
              st_r <= wpts_pkg::S_HALT; // RULE_03 RULE_09
            end else begin
              st_r <= wpts_pkg::S_DEAD; // RULE_07
            end
          end
        end
        wpts_pkg::S_DEAD: begin
          if (dead_r == wpts_pkg::DEAD_W'(wpts_pkg::DEAD_CYC - 1)) begin
            st_r <= wpts_pkg::S_ARMED; // RULE_07
          end
        end
        wpts_pkg::S_HALT: begin
          st_r <= wpts_pkg::S_HALT; // RULE_04 RULE_10
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || st_r != wpts_pkg::S_DEAD) begin
      dead_r <= '0;
    end else begin
      dead_r <= wpts_pkg::DEAD_W'(dead_r + 1'b1); // RULE_07
    end
  end

  // Aborted output is flushed rather than left to drain late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      abort_r <= 1'b0;
    end else begin
      abort_r <= stop_now;
    end
  end

  // Address walk, inner loop, outer passes and pad repeats
  always_ff @(posedge i_clk) begin
    if (i_rst || st_r != wpts_pkg::S_RUN) begin
      addr_r  <= '0;
      pass_r  <= '0;
      rep_r   <= '0;
      ocnt_r  <= '0;
      icnt_r  <= '0;
      first_r <= 1'b1;
    end else if (issue) begin
      first_r <= 1'b0;
      ocnt_r  <= wpts_pkg::PAD_W'(ocnt_r + 1'b1);
      icnt_r  <= wpts_pkg::PAD_W'(icnt_r + 1'b1);
      if (at_inner && !pad_in) begin
        addr_r <= i_inner_start; // RULE_02
        rep_r  <= 16'(rep_r + 1'b1);
        icnt_r <= '0;
      end else if (at_outer && !at_inner && !pad_out) begin
        addr_r  <= '0;
        pass_r  <= 16'(pass_r + 1'b1);
        rep_r   <= '0;
        ocnt_r  <= '0;
        first_r <= 1'b1; // RULE_01
      end else if (!(at_inner || at_outer)) begin
        addr_r <= AW'(addr_r + 1'b1);
        if (addr_r == AW'(i_inner_start - 1'b1)) begin
          icnt_r <= '0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mem_rd   <= 1'b0;
      o_mem_addr <= '0;
      o_playing  <= 1'b0;
    end else begin
      o_mem_rd   <= issue;
      o_playing  <= (st_r == wpts_pkg::S_RUN);
      if (issue) begin
        o_mem_addr <= addr_r;
      end
    end
  end

  // Sync flag travels with its sample through the buffer
  logic first_d_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      first_d_r <= 1'b0;
    end else if (issue) begin
      first_d_r <= first_r;
    end
  end

  wpts_fifo #(
    .W     (SW + 1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_flush     (abort_r),
    .i_in_valid  (o_mem_rd & ~abort_r),
    .i_in_data   ({first_d_r, i_mem_data}),
    .o_in_ready  (fifo_rdy),
    .o_out_valid (fifo_vld),
    .o_out_data  (fifo_dat),
    .i_out_ready (tick),
    .o_count     (fifo_cnt)
  );

  // Modifiers are plain registers, so they change without touching memory
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      shift_r          <= wpts_pkg::SHIFT_RST;
      o_noise_level    <= '0;
      o_noise_band     <= wpts_pkg::NB_RST;
      o_lowpass_select <= wpts_pkg::LP_RST;
      mark_dly_r       <= '0;
      div_r            <= wpts_pkg::DIV_RST;
    end else if (i_mod_wr) begin
      shift_r       <= i_dc_shift;    // RULE_20
      o_noise_level <= i_noise_level; // RULE_20
      mark_dly_r    <= i_marker_delay;
      div_r         <= i_rate_div;
      if (i_noise_band <= wpts_pkg::NB_20K) begin
        o_noise_band <= i_noise_band; // RULE_17
      end
      if (i_lowpass_select < wpts_pkg::LP_COUNT) begin
        o_lowpass_select <= i_lowpass_select; // RULE_18
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rate_r <= '0;
    end else begin
      rate_r <= tick ? div_r : wpts_pkg::DIV_W'(rate_r - 1'b1); // RULE_20
    end
  end

  assign sum = $signed({fifo_dat[SW-1], fifo_dat[SW-1:0]}) + $signed({shift_r[SW-1], shift_r});

  // Last sample is held; only a drained sample replaces it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sample     <= '0;
      o_sample_vld <= 1'b0;
      o_sync       <= 1'b0;
    end else begin
      o_sample_vld <= drain;
      o_sync       <= drain & fifo_dat[SW]; // RULE_01 RULE_02
      if (drain) begin
        if (sum > $signed({FS_POS[SW-1], FS_POS})) begin
          o_sample <= FS_POS; // RULE_19
        end else if (sum < $signed({FS_NEG[SW-1], FS_NEG})) begin
          o_sample <= FS_NEG; // RULE_19
        end else begin
          o_sample <= sum[SW-1:0]; // RULE_04
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_marker    <= 1'b0;
      mark_cnt_r  <= '0;
      mark_pend_r <= 1'b0;
    end else if (drain && fifo_dat[SW]) begin
      o_marker    <= 1'b0;
      mark_cnt_r  <= mark_dly_r;
      mark_pend_r <= 1'b1;
    end else if (mark_pend_r) begin
      if (mark_cnt_r <= 16'h0001) begin
        o_marker    <= 1'b1; // RULE_16
        mark_pend_r <= 1'b0;
      end
      if (mark_cnt_r != '0) begin
        mark_cnt_r <= wpts_pkg::MARK_W'(mark_cnt_r - 1'b1);
      end
    end
  end

  sync_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_sync |-> o_sample_vld ##1 !o_sync) else $error("sync not a single cycle"); // RULE_01
  inner_nosync_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (issue && at_inner && !pad_in) |=> !first_r) else $error("inner loop set sync"); // RULE_02
  dead_time_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_run)
    (st_r == wpts_pkg::S_DEAD ##1 st_r == wpts_pkg::S_ARMED)
    |-> $past(dead_r) == 7'h3E) else $error("dead time wrong"); // RULE_07
  no_retrig_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_run)
    (st_r == wpts_pkg::S_RUN && mode_r == wpts_pkg::MODE_START && !eq_end)
    |=> st_r == wpts_pkg::S_RUN) else $error("start mode retriggered"); // RULE_06
  edge_stop_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_run)
    (st_r == wpts_pkg::S_RUN && mode_r == wpts_pkg::MODE_STOP && trig_edge)
    |=> st_r == wpts_pkg::S_HALT ##1 st_r == wpts_pkg::S_HALT) else $error("edge stop"); // RULE_09
  halt_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_r == wpts_pkg::S_HALT && i_run) |=> !o_mem_rd && $stable(o_mem_addr))
    else $error("halt not holding"); // RULE_04
  gate_off_a: assert property (@(posedge i_clk) disable iff (i_rst || !i_run)
    (st_r == wpts_pkg::S_RUN && mode_r == wpts_pkg::MODE_GATED && !trig_lvl)
    |=> st_r == wpts_pkg::S_ARMED) else $error("gate did not stop"); // RULE_13
  run_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_run |=> st_r == wpts_pkg::S_IDLE) else $error("run low ignored"); // RULE_03
  mode_legal_a: assert property (@(posedge i_clk) disable iff (i_rst)
    mode_r <= wpts_pkg::MODE_GATED) else $error("illegal mode latched"); // RULE_14
  band_legal_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_noise_band != 2'h3 && o_lowpass_select < 4'hA) else $error("bad modifier"); // RULE_17
  marker_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_sync && mark_dly_r > 16'h0002) |-> !o_marker ##1 !o_marker)
    else $error("marker early"); // RULE_16

  sync_c: cover property (@(posedge i_clk) disable iff (i_rst) o_sync);
  marker_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_marker));
  rearm_c: cover property (@(posedge i_clk) disable iff (i_rst)
    st_r == wpts_pkg::S_DEAD ##1 st_r == wpts_pkg::S_ARMED);
  halt_c: cover property (@(posedge i_clk) disable iff (i_rst) st_r == wpts_pkg::S_HALT);
endmodule : wpts_seq
`default_nettype wire

//--- src/wpts_pkg.sv
package wpts_pkg;

  // Timing
  localparam int CLK_MHZ  = 125;
  localparam int DEAD_NS  = 500;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_W   = 7;

  // Widths and depths
  localparam int SAMPLE_W   = 16;
  localparam int AW         = 16;
  localparam int LOOP_W     = 16;
  localparam int MARK_W     = 16;
  localparam int DIV_W      = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int PAD_W      = 4;

  localparam logic [PAD_W-1:0] PAD_LAST = 4'hF;

  // Trigger scheme codes
  localparam logic [2:0] MODE_FREE  = 3'h0;
  localparam logic [2:0] MODE_START = 3'h1;
  localparam logic [2:0] MODE_STOP  = 3'h2;
  localparam logic [2:0] MODE_SS    = 3'h3;
  localparam logic [2:0] MODE_GATED = 3'h4;

  // Noise band codes: 2 MHz, 200 kHz, 20 kHz
  localparam logic [1:0] NB_2M   = 2'h0;
  localparam logic [1:0] NB_200K = 2'h1;
  localparam logic [1:0] NB_20K  = 2'h2;

  // Low-pass codes 0..9: 20k, 50k, 100k, 200k, 500k, 1M, 2M, 5M, 10M, 20M
  localparam logic [3:0] LP_COUNT = 4'hA;

  // Reset values
  localparam logic [1:0]          NB_RST    = 2'h0;
  localparam logic [3:0]          LP_RST    = 4'h0;
  localparam logic [SAMPLE_W-1:0] SHIFT_RST = 16'h0000;
  localparam logic [DIV_W-1:0]    DIV_RST   = 16'h0000;

  // Full scale codes for +5 V and -5 V
  localparam logic signed [SAMPLE_W-1:0] FS_POS = 16'sh7FFF;
  localparam logic signed [SAMPLE_W-1:0] FS_NEG = 16'sh8000;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_ARMED = 5'h02,
    S_RUN   = 5'h04,
    S_DEAD  = 5'h08,
    S_HALT  = 5'h10
  } wpts_state_t;

  function automatic logic [2:0] wpts_mode_f(input logic [2:0] m);
    wpts_mode_f = (m > MODE_GATED) ? MODE_FREE : m;
  endfunction : wpts_mode_f

endpackage : wpts_pkg

//--- src/wpts_trig_cond.sv
`timescale 1ns/1ps
`default_nettype none
module wpts_trig_cond (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Trigger pin and polarity
  input  wire logic i_pin,
  input  wire logic i_neg,
  // Conditioned trigger
  output logic      o_level_r,
  output logic      o_edge_r
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic stable_r;
  logic act;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Change accepted once two later stages agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stable_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      stable_r <= s3_r; // RULE_23
    end
  end

  assign act = stable_r ^ i_neg; // RULE_15

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level_r <= 1'b0;
      o_edge_r  <= 1'b0;
    end else begin
      o_level_r <= act;
      o_edge_r  <= act & ~o_level_r; // RULE_23
    end
  end
endmodule : wpts_trig_cond
`default_nettype wire

//--- src/wpts_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module wpts_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_flush,
  // Fill side
  input  wire logic          i_in_valid,
  input  wire logic [W-1:0]  i_in_data,
  output logic               o_in_ready,
  // Drain side
  output logic               o_out_valid,
  output logic [W-1:0]       o_out_data,
  input  wire logic          i_out_ready,
  // Fill level
  output logic [CW-1:0]      o_count
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic          push;
  logic          pop;

  assign o_in_ready  = (cnt_r != CW'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data  = mem_r[rp_r];
  assign o_count     = cnt_r;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || i_flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : PW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : PW'(rp_r + 1'b1);
      end
      if (push && !pop) begin
        cnt_r <= CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
        cnt_r <= CW'(cnt_r - 1'b1);
      end
    end
  end
endmodule : wpts_fifo
`default_nettype wire

//--- verification/wpts_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module wpts_trig_src (
  input  wire logic i_clk,
  input  wire logic i_neg,
  output var logic  o_pin
);
  // Starts low, the inactive level when i_neg is low, so only fire() makes an edge
  initial o_pin = 1'b0;
  // Pulse held 3 cycles so the 3-flop synchroniser cannot miss it
  task automatic fire();
    @(posedge i_clk);
    #1 o_pin = ~i_neg;
    repeat (3) @(posedge i_clk);
    #1 o_pin = i_neg;
  endtask : fire
endmodule : wpts_trig_src
`default_nettype wire

//--- verification/tb_waveform_playback_trigger_seq.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_waveform_playback_trigger_seq;
  logic i_clk = 0, i_rst = 1, pin, run = 0, mod_wr = 0, hs = 0, neg = 0, marker;
  logic [2:0] mode = 0;
  logic [1:0] nb = 0, o_nb;
  logic [3:0] lp = 0, o_lp;
  logic [15:0] len = 1, loops = 1, icnt = 1, dc = 0, div = 0, mem_q, smp;
  logic vld, sync, playing, rd;
  logic [15:0] addr;
  logic [16:0] q[$], e;
  int n_mismatch = 0, checks = 0, cyc = 0;
  always #4 i_clk = ~i_clk;
  wpts_trig_src src (.i_clk(i_clk), .i_neg(neg), .o_pin(pin));
  wpts_seq uut (.i_clk(i_clk), .i_rst(i_rst), .i_trig_pin(pin), .i_trig_mode(mode),
    .i_trig_neg(neg), .i_run(run), .i_compute_done(1'b1), .i_hs_mode(hs), .i_seq_len(len),
    .i_loop_directive(loops), .i_inner_start(16'h0001), .i_inner_len(16'h0002),
    .i_inner_count(icnt), .i_mod_wr(mod_wr), .i_dc_shift(dc), .i_noise_level(dc),
    .i_noise_band(nb), .i_lowpass_select(lp), .i_marker_delay(16'h0003), .i_rate_div(div),
    .o_mem_rd(rd), .o_mem_addr(addr), .i_mem_data(mem_q), .o_sample_vld(vld), .o_sample(smp),
    .o_sync(sync), .o_marker(marker), .o_noise_level(), .o_noise_band(o_nb),
    .o_lowpass_select(o_lp), .o_playing(playing));
  // Memory answers within the read cycle; the buffer takes data at that cycle's end
  always_comb mem_q = addr + 16'h0100;
  function automatic logic [15:0] sat(input logic [15:0] d, input logic [15:0] s);
    logic signed [16:0] t;
    t = $signed({d[15], d}) + $signed({s[15], s});
    sat = (t > 17'sd32767) ? 16'h7FFF : (t < -17'sd32768) ? 16'h8000 : t[15:0];
  endfunction : sat
  always @(posedge i_clk) if (vld === 1'b1) begin
    if (q.size() == 0) `CHK(vld, 1'b0)
    else begin
      e = q.pop_front();
      `CHK(smp, e[15:0])
      `CHK(sync, e[16])
    end
  end
  task automatic setmod(input logic [1:0] b, input logic [3:0] l, input logic [15:0] s);
    @(posedge i_clk);
    #1 mod_wr = 1; nb = b; lp = l; dc = s;
    @(posedge i_clk);
    #1 mod_wr = 0;
  endtask : setmod
  // Arms the run and notes expected samples; inner loop repeats addresses 1..2
  task automatic play(input logic [2:0] m, input int n, input int ln, input int ic);
    @(posedge i_clk);
    #1 run = 0; mode = m; loops = 16'(n); len = 16'(ln); icnt = 16'(ic);
    // Two idle cycles so the scheme is latched before run rises
    repeat (2) @(posedge i_clk);
    #1 run = 1;
    for (int p = 0; p < n; p++) for (int a = 0; a < ln; a++) begin
      q.push_back({a == 0, sat(16'(a) + 16'h0100, dc)});
      if (a == 2) for (int r = 1; r < ic; r++) begin
        q.push_back({1'b0, sat(16'h0101, dc)});
        q.push_back({1'b0, sat(16'h0102, dc)});
      end
    end
  endtask : play
  task automatic drain();
    for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge i_clk);
    `CHK(q.size(), 0)
  endtask : drain
  task automatic test_done();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hd132));
    repeat (3) @(posedge i_clk);
    #1 i_rst = 0;
    setmod(2'h1, 4'h9, 16'h0000);
    `CHK({o_nb, o_lp}, {2'h1, 4'h9})
    setmod(2'h3, 4'hA, 16'($urandom & 32'h0FFF));
    `CHK({o_nb, o_lp}, {2'h1, 4'h9})
    play(3'h0, 2, 3, 1);
    drain();
    repeat (80) @(posedge i_clk);
    `CHK(playing, 1'b0)
    `CHK(marker, 1'b1)
    // Inner loop: one sync per outer pass only
    play(3'h7, 2, 4, 2);
    drain();
    setmod(2'h0, 4'h0, 16'h7F80);
    play(3'h1, 1, 3, 1);
    repeat (30) @(posedge i_clk);
    `CHK(playing, 1'b0)
    src.fire();
    drain();
    // Edge inside the dead time must be refused
    src.fire();
    repeat (80) @(posedge i_clk);
    `CHK(playing, 1'b0)
    play(3'h1, 1, 3, 1);
    #1 run = 1;
    src.fire();
    drain();
    // Slow drain fills the buffer; samples must still leave in order
    div = 16'h0003;
    setmod(2'h2, 4'h3, 16'h0000);
    `CHK({o_nb, o_lp}, {2'h2, 4'h3})
    play(3'h0, 1, 20, 1);
    drain();
    test_done();
  end
endmodule : tb_waveform_playback_trigger_seq
`default_nettype wire
